// ===== core/bipb_sync.sv
/*
 * bipb_pkg: constants for the bidirectional io port bank.
 * bipb_sync: two-flop synchroniser for pin levels.
 * assumes: one system clock; pins change freely against it.
 */

// ****************************************************************
// constants
// ****************************************************************
package bipb_pkg;
    localparam int         NBITS        = 28;
    localparam int         AXI_AW       = 12;
    localparam int         P0_LSB       = 0;
    localparam int         P1_LSB       = 8;
    localparam int         P2_LSB       = 16;
    localparam int         P3_LSB       = 20;
    localparam logic [7:0] RIDX_DIR0    = 8'h00e0;
    localparam logic [7:0] RIDX_DIR1    = 8'h00e1;
    localparam logic [7:0] RIDX_DIR2    = 8'h00e2;
    localparam logic [7:0] RIDX_DIR3    = 8'h00e3;
    localparam logic [7:0] RIDX_DAT0    = 8'h00e4;
    localparam logic [7:0] RIDX_DAT1    = 8'h00e5;
    localparam logic [7:0] RIDX_DAT2    = 8'h00e6;
    localparam logic [7:0] RIDX_DAT3    = 8'h00e7;
    localparam logic [7:0] RIDX_MODE    = 8'h00e8;
    localparam logic [27:0] DIR_RST     = 28'h000_0000;
    localparam logic [27:0] DAT_RST     = 28'hfff_ffff;
    localparam logic [4:0] MODE_RST     = 5'h00;
    localparam int         MODE_XBUS    = 0;
    localparam int         MODE_SER_LSB = 1;
    localparam int         MODE_GRP     = 4;
    localparam logic [2:0] SER_OFF      = 3'h0;
    localparam logic [2:0] SER_ASYNC    = 3'h1;
    localparam logic [2:0] SER_SLAVE    = 3'h2;
    localparam logic [2:0] SER_MASTER   = 3'h3;
    localparam logic [2:0] SER_IRDA     = 3'h4;
    localparam logic [3:0] CLAIM_ASYNC  = 4'h3;
    localparam logic [3:0] CLAIM_SLAVE  = 4'hf;
    localparam logic [3:0] CLAIM_MASTER = 4'h7;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// synchroniser
// ****************************************************************
module bipb_sync #(
    parameter int W = 28
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk)
    begin
        meta <= d;
        q    <= meta;
    end
endmodule

`default_nettype wire

// ===== core/bipb_port_bank.sv
/*
 * bipb_port_bank: 28-bit general purpose port bank with axi4-lite
 * registers, expanded data bus takeover on port 0 and serial
 * takeover on port 1.
 * assumes: one 250 MHz clock, synchronous active-low reset; a bus
 * controller and a serial core sit outside and drive the alt inputs.
 */
// Operation
// RQ1: 28 port bits in four ports
// RQ2: serial mode decides which port 1 bits
// RQ3: unclaimed port 1 bits stay general purpose
// RQ4: claimed bits keep registers as plain storage
// RQ5: fixed serial signal placement on port 1
// RQ6: port 0 carries data bus in expanded mode
// RQ7: port 0 registers inert outside single-chip mode
// RQ8: pull-up presence fixed per bit at build
// RQ9: pull-up on only in input mode
// RQ10: software waits for pull-up rise time
// RQ11: direction 0 means input, driver off
// RQ12: input mode read returns pin level
// RQ13: data write in input mode leaves pin
// RQ14: direction 1 enables the output driver
// RQ15: output mode drives data bit level
// RQ16: output mode read returns data register
// RQ17: reset clears all direction bits
// RQ18: reset sets all data bits
// RQ19: pin levels pass two-flop synchroniser

`timescale 1ns/1ps
`default_nettype none

module bipb_port_bank
    import bipb_pkg::*;
#(
    // RQ8: build-time pull-up option
    parameter logic [NBITS-1:0] PULLUP_MASK = 28'hfff_ffff
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NBITS-1:0]  pin_i,
    output var  logic [NBITS-1:0]  pin_o,
    output var  logic [NBITS-1:0]  pin_oe,
    output var  logic [NBITS-1:0]  pullup_en,
    input  wire logic [7:0]        dbus_o,
    input  wire logic              dbus_oe,
    output var  logic [7:0]        dbus_i,
    input  wire logic              serial_tx_out,
    input  wire logic              infrared_tx_out,
    input  wire logic              serial_ready_out,
    input  wire logic              sclk_o,
    input  wire logic              sclk_oe,
    output var  logic              serial_rx_in,
    output var  logic              infrared_rx_in,
    output var  logic              sclk_i
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic idx_ok(input logic [AXI_AW-1:0] a);
        logic [7:0] ix;
        ix = a[9:2];
        return (a[AXI_AW-1:10] == 2'h0) && (a[1:0] == 2'h0)
            && (ix >= RIDX_DIR0) && (ix <= RIDX_MODE);
    endfunction

    // RQ2: claimed port 1 bits per serial mode
    function automatic logic [7:0] claim_of(input logic [4:0] m);
        logic [3:0] nib;
        logic [2:0] sm;
        sm  = m[MODE_SER_LSB +: 3];
        nib = 4'h0;
        if (sm == SER_ASYNC)
            nib = CLAIM_ASYNC;
        else if (sm == SER_SLAVE)
            nib = CLAIM_SLAVE;
        else if (sm == SER_MASTER)
            nib = CLAIM_MASTER;
        if (sm == SER_IRDA)
            return {CLAIM_ASYNC, 4'h0};
        return m[MODE_GRP] ? {nib, 4'h0} : {4'h0, nib};
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [NBITS-1:0]  pin_d;
    logic [NBITS-1:0]  dir;
    logic [NBITS-1:0]  data;
    logic [4:0]        mode;
    logic [NBITS-1:0]  next_dir;
    logic [NBITS-1:0]  next_data;
    logic [4:0]        next_mode;
    logic              aw_full;
    logic              w_full;
    logic [AXI_AW-1:0] aw_addr;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              next_aw_full;
    logic              next_w_full;
    logic [AXI_AW-1:0] next_aw_addr;
    logic [7:0]        next_w_byte;
    logic              next_w_lane0;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic [NBITS-1:0]  next_pin_o;
    logic [NBITS-1:0]  next_pin_oe;
    logic [NBITS-1:0]  rd_bits;
    logic [7:0]        claim;
    logic              grp_hi;
    logic              do_wr;

    // RQ19: two flops before any logic reads a pin
    bipb_sync #(
        .W (NBITS)
    ) bipb_sync_i (
        .clk (clk),
        .d   (pin_i),
        .q   (pin_d)
    );

    // ************************************************************
    // axi write channel and register storage
    // ************************************************************
    assign do_wr = aw_full & w_full & ~s_axi_bvalid;

    always_comb
    begin
        next_dir     = dir;
        next_data    = data;
        next_mode    = mode;
        next_aw_full = aw_full | (s_axi_awvalid & s_axi_awready);
        next_w_full  = w_full | (s_axi_wvalid & s_axi_wready);
        next_aw_addr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr
                                                       : aw_addr;
        next_w_byte  = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata[7:0]
                                                     : w_byte;
        next_w_lane0 = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0]
                                                     : w_lane0;
        next_bvalid  = s_axi_bvalid & ~s_axi_bready;
        next_bresp   = s_axi_bresp;
        if (do_wr)
        begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = idx_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            // RQ4: claimed bits still store, pins unaffected
            // RQ13: data stored regardless of direction
            if (idx_ok(aw_addr) && w_lane0)
            begin
                // RQ1: ports of 8, 8, 4 and 8 bits
                unique case (aw_addr[9:2])
                    RIDX_DIR0: next_dir[P0_LSB +: 8]  = w_byte;
                    RIDX_DIR1: next_dir[P1_LSB +: 8]  = w_byte;
                    RIDX_DIR2: next_dir[P2_LSB +: 4]  = w_byte[3:0];
                    RIDX_DIR3: next_dir[P3_LSB +: 8]  = w_byte;
                    RIDX_DAT0: next_data[P0_LSB +: 8] = w_byte;
                    RIDX_DAT1: next_data[P1_LSB +: 8] = w_byte;
                    RIDX_DAT2: next_data[P2_LSB +: 4] = w_byte[3:0];
                    RIDX_DAT3: next_data[P3_LSB +: 8] = w_byte;
                    default:   next_mode = w_byte[4:0];
                endcase
            end
        end
        next_awready = ~next_aw_full & ~next_bvalid;
        next_wready  = ~next_w_full & ~next_bvalid;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            // RQ17: all bits start as inputs
            dir           <= DIR_RST;
            // RQ18: data latches start high
            data          <= DAT_RST;
            mode          <= MODE_RST;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            dir           <= next_dir;
            data          <= next_data;
            mode          <= next_mode;
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            aw_addr       <= next_aw_addr;
            w_byte        <= next_w_byte;
            w_lane0       <= next_w_lane0;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    // ************************************************************
    // axi read channel
    // ************************************************************
    // RQ12: input bits read the synchronised pin
    // RQ16: output bits read the data latch
    assign rd_bits = (dir & data) | (~dir & pin_d);

    always_comb
    begin
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0000_0000;
            next_rresp  = idx_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (idx_ok(s_axi_araddr))
            begin
                unique case (s_axi_araddr[9:2])
                    RIDX_DIR0: next_rdata[7:0] = dir[P0_LSB +: 8];
                    RIDX_DIR1: next_rdata[7:0] = dir[P1_LSB +: 8];
                    RIDX_DIR2: next_rdata[3:0] = dir[P2_LSB +: 4];
                    RIDX_DIR3: next_rdata[7:0] = dir[P3_LSB +: 8];
                    RIDX_DAT0: next_rdata[7:0] = rd_bits[P0_LSB +: 8];
                    RIDX_DAT1: next_rdata[7:0] = rd_bits[P1_LSB +: 8];
                    RIDX_DAT2: next_rdata[3:0] = rd_bits[P2_LSB +: 4];
                    RIDX_DAT3: next_rdata[7:0] = rd_bits[P3_LSB +: 8];
                    default:   next_rdata[4:0] = mode;
                endcase
            end
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ************************************************************
    // pin drive and alternate functions
    // ************************************************************
    assign claim  = claim_of(mode);
    assign grp_hi = mode[MODE_GRP]
                  | (mode[MODE_SER_LSB +: 3] == SER_IRDA);

    always_comb
    begin
        // RQ11: direction 0 turns driver off
        // RQ14: direction 1 turns driver on
        // RQ15: driven level follows data latch
        next_pin_o  = data;
        next_pin_oe = dir;
        // RQ6: port 0 becomes the data bus
        // RQ7: port 0 registers no longer reach pins
        if (mode[MODE_XBUS])
        begin
            next_pin_o[P0_LSB +: 8]  = dbus_o;
            next_pin_oe[P0_LSB +: 8] = {8{dbus_oe}};
        end
        // RQ3: unclaimed port 1 bits keep gpio drive
        // RQ5: fixed role per bit position
        for (int k = 0; k < 8; k++)
        begin
            if (claim[k])
            begin
                unique case (k % 4)
                    0:
                    begin
                        next_pin_o[P1_LSB + k]  = 1'b0;
                        next_pin_oe[P1_LSB + k] = 1'b0;
                    end
                    1:
                    begin
                        next_pin_o[P1_LSB + k]  =
                            (mode[MODE_SER_LSB +: 3] == SER_IRDA)
                            ? infrared_tx_out : serial_tx_out;
                        next_pin_oe[P1_LSB + k] = 1'b1;
                    end
                    2:
                    begin
                        next_pin_o[P1_LSB + k]  = sclk_o;
                        next_pin_oe[P1_LSB + k] = sclk_oe;
                    end
                    default:
                    begin
                        next_pin_o[P1_LSB + k]  = serial_ready_out;
                        next_pin_oe[P1_LSB + k] = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pin_o          <= DAT_RST;
            pin_oe         <= DIR_RST;
            pullup_en      <= PULLUP_MASK;
            dbus_i         <= 8'h00;
            serial_rx_in   <= 1'b1;
            infrared_rx_in <= 1'b1;
            sclk_i         <= 1'b1;
        end
        else
        begin
            pin_o          <= next_pin_o;
            pin_oe         <= next_pin_oe;
            // RQ9: pull-up only while not driven
            pullup_en      <= PULLUP_MASK & ~next_pin_oe;
            dbus_i         <= pin_d[P0_LSB +: 8];
            serial_rx_in   <= grp_hi ? pin_d[P1_LSB + 4] : pin_d[P1_LSB];
            infrared_rx_in <= pin_d[P1_LSB + 4];
            sclk_i         <= grp_hi ? pin_d[P1_LSB + 6] : pin_d[P1_LSB + 2];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_reset_dir_clear: assert property ( // RQ17
        $past(!nrst) |-> (dir == DIR_RST) && (pin_oe == DIR_RST))
        else $error("direction not cleared by reset");
    chk_reset_data_set: assert property ( // RQ18
        $past(!nrst) |-> data == DAT_RST)
        else $error("data not set by reset");
    chk_pullup_input_only: assert property ( // RQ9
        pullup_en == (PULLUP_MASK & ~pin_oe))
        else $error("pull-up on while driving");
    chk_output_level: assert property ( // RQ15
        !mode[MODE_XBUS] && claim == 8'h00 |=>
        ((pin_o ^ $past(data)) & $past(dir)) == '0)
        else $error("output level differs from data");
    chk_input_hiz: assert property ( // RQ11
        !mode[MODE_XBUS] && claim == 8'h00 |=>
        (pin_oe & ~$past(dir)) == '0)
        else $error("input bit driven");
    chk_bus_port0: assert property ( // RQ6
        mode[MODE_XBUS] |=> pin_oe[7:0] == {8{$past(dbus_oe)}}
        && pin_o[7:0] == $past(dbus_o))
        else $error("port 0 not following data bus");
    chk_gpio_port1: assert property ( // RQ3
        claim == 8'h00 |=> pin_oe[15:8] == $past(dir[15:8]))
        else $error("port 1 not under gpio control");
    chk_sync_delay: assert property ( // RQ19
        pin_d == $past(pin_i, 2))
        else $error("pin path not two stages");
    chk_write_answer: assert property ( // RQ13
        do_wr && !mode[MODE_XBUS] && claim == 8'h00
        && aw_addr[9:2] >= RIDX_DAT0 && aw_addr[9:2] <= RIDX_DAT3
        |=> s_axi_bvalid ##1 pin_oe == $past(dir, 2))
        else $error("data write moved the pin drive");

endmodule

`default_nettype wire

// ===== tb/bipb_pin_model.sv
/*
 * bipb_pin_model: board side of the port bank pins.
 * assumes: no clock; the bench drives ext_val/ext_oe for outside
 * drivers; the bank's own driver wins over any outside driver.
 */
`timescale 1ns/1ps
`default_nettype none

// ********
// pin level resolution
// ********
module bipb_pin_model
    import bipb_pkg::*;
(
    input  wire logic [NBITS-1:0] pin_o,
    input  wire logic [NBITS-1:0] pin_oe,
    input  wire logic [NBITS-1:0] pullup_en,
    input  wire logic [NBITS-1:0] ext_val,
    input  wire logic [NBITS-1:0] ext_oe,
    output var  logic [NBITS-1:0] pin_i
);
    // floating bits without pull-up show the inverse of the latch,
    // so a stale level never passes for a real one
    // bank drive first, then outside
    always_comb
    begin
        pin_i = (pin_oe & pin_o)
              | (~pin_oe & ext_oe & ext_val)
              | (~pin_oe & ~ext_oe & (pullup_en | ~pin_o));
    end
endmodule

`default_nettype wire

// ===== tb/test_bipb_port_bank.sv
/*
 * test_bipb_port_bank: self-checking bench for the port bank.
 * assumes: bipb_pkg, the bank and bipb_pin_model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_bipb_port_bank;
    import bipb_pkg::*;
    localparam logic [NBITS-1:0] PU_MASK = 28'hfff_0f0f;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic [11:0]      s_axi_awaddr = '0, s_axi_araddr = '0;
    logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic             s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic             s_axi_rready = 1'b0;
    logic [31:0]      s_axi_wdata = '0, s_axi_rdata, rd_val;
    logic [3:0]       s_axi_wstrb = '0;
    logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic             s_axi_arready, s_axi_rvalid;
    logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
    logic [NBITS-1:0] pin_i, pin_o, pin_oe, pullup_en;
    logic [NBITS-1:0] ext_val = '0, ext_oe = '0;
    logic [7:0]       dbus_o = '0, dbus_i;
    logic             dbus_oe = 1'b0, serial_tx_out = 1'b0;
    logic             infrared_tx_out = 1'b0, serial_ready_out = 1'b0;
    logic             sclk_o = 1'b0, sclk_oe = 1'b0;
    logic             serial_rx_in, infrared_rx_in, sclk_i;
    int               miscompares = 0, n_tests = 0;

    bipb_port_bank #(.PULLUP_MASK(PU_MASK)) bipb_port_bank_i (
        .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o, .pin_oe,
        .pullup_en, .dbus_o, .dbus_oe, .dbus_i, .serial_tx_out,
        .infrared_tx_out, .serial_ready_out, .sclk_o, .sclk_oe,
        .serial_rx_in, .infrared_rx_in, .sclk_i);

    bipb_pin_model bipb_pin_model_i (.pin_o, .pin_oe, .pullup_en,
        .ext_val, .ext_oe, .pin_i);

    // ********
    // clock, watchdog, verdict
    // ********
    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        end_of_test();
    end

    // ********
    // bus tasks
    // ********
    function automatic logic [11:0] ra(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        bit done;
        int n;
        done = 0;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 64)
        begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) miscompares++;
    endtask

    task automatic axr(input logic [11:0] a);
        bit done;
        int n;
        done = 0;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 64)
        begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                resp = s_axi_rresp;
                rd_val = s_axi_rdata;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) miscompares++;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        axr(ra(idx));
        `CHK(rd_val, e)
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reset();
        `CHK(pin_oe, 28'h000_0000)
        `CHK(pin_o, 28'hfff_ffff)
        `CHK(pullup_en, PU_MASK)
        for (int i = 0; i < 4; i++)
            rdchk(8'(RIDX_DIR0 + i), 32'h0000_0000);
        axw(ra(RIDX_DIR3), 32'h0000_00ff);
        cyc(2);
        `CHK(pin_oe[27:20], 8'hff)
        `CHK(pin_o[27:20], 8'hff)
        rdchk(RIDX_DAT3, 32'h0000_00ff);
        axw(ra(RIDX_DIR3), 32'h0000_0000);
    endtask

    task automatic t_input();
        int lsb[4];
        lsb = '{P0_LSB, P1_LSB, P2_LSB, P3_LSB};
        ext_oe <= 28'hfff_ffff;
        ext_val <= 28'ha5c_3e69;
        cyc(4);
        for (int i = 0; i < 4; i++)
            rdchk(8'(RIDX_DAT0 + i), 32'((ext_val >> lsb[i]) &
                (i == 2 ? 28'h000_000f : 28'h000_00ff)));
        axw(ra(RIDX_DAT1), 32'h0000_0000);
        cyc(2);
        `CHK(pin_oe[15:8], 8'h00)
        rdchk(RIDX_DAT1, 32'h0000_003e);
    endtask

    task automatic t_output();
        ext_val[27:20] <= 8'hc0;
        axw(ra(RIDX_DAT3), 32'h0000_0035);
        axw(ra(RIDX_DIR3), 32'h0000_000f);
        cyc(2);
        `CHK(pin_oe[27:20], 8'h0f)
        `CHK(pin_o[23:20], 4'h5)
        `CHK(pullup_en[27:20], 8'hf0)
        `CHK(pullup_en[15:0], PU_MASK[15:0])
        cyc(4);
        rdchk(RIDX_DAT3, 32'h0000_00c5);
        ext_oe[27:20] <= 8'h00;
        axw(ra(RIDX_DIR3), 32'h0000_0000);
        cyc(8);
        rdchk(RIDX_DAT3, 32'h0000_00ff);
    endtask

    task automatic t_xbus();
        axw(ra(RIDX_DIR0), 32'h0000_00ff);
        axw(ra(RIDX_DAT0), 32'h0000_0000);
        axw(ra(RIDX_MODE), 32'h0000_0001);
        dbus_oe <= 1'b1;
        dbus_o <= 8'h3c;
        cyc(2);
        `CHK(pin_oe[7:0], 8'hff)
        `CHK(pin_o[7:0], 8'h3c)
        dbus_oe <= 1'b0;
        ext_val[7:0] <= 8'h96;
        cyc(6);
        `CHK(pin_oe[7:0], 8'h00)
        `CHK(dbus_i, 8'h96)
        axw(ra(RIDX_DAT0), 32'h0000_0011);
        rdchk(RIDX_DIR0, 32'h0000_00ff);
        rdchk(RIDX_DAT0, 32'h0000_0011);
        axw(ra(RIDX_MODE), 32'h0000_0000);
        cyc(2);
        `CHK(pin_o[7:0], 8'h11)
        axw(ra(RIDX_DIR0), 32'h0000_0000);
    endtask

    task automatic t_serial();
        logic [2:0] md[4];
        logic [3:0] cl[4];
        logic       hi;
        logic [7:0] eoe, eo;
        md = '{SER_ASYNC, SER_SLAVE, SER_MASTER, SER_IRDA};
        cl = '{4'h3, 4'hf, 4'h7, 4'h3};
        ext_val[15:8] <= 8'h11;
        serial_tx_out <= 1'b1;
        infrared_tx_out <= 1'b0;
        serial_ready_out <= 1'b1;
        sclk_o <= 1'b1;
        sclk_oe <= 1'b1;
        axw(ra(RIDX_DIR1), 32'h0000_00ff);
        for (int k = 0; k < 7; k++)
        begin
            hi = k[0] || (k == 6);
            axw(ra(RIDX_MODE), 32'({hi, md[k/2], 1'b0}));
            cyc(4);
            eoe = ~(8'h01 << (hi ? 4 : 0));
            eo = 8'({4'h0, cl[k/2] & (k == 6 ? 4'hc : 4'he)})
                 << (hi ? 4 : 0);
            `CHK(pin_oe[15:8], eoe)
            `CHK(pin_o[15:8], eo)
            if (k == 6)
                `CHK(infrared_rx_in, 1'b1)
            else
                `CHK(serial_rx_in, 1'b1)
            `CHK(sclk_i, 1'(k >= 2 && k <= 5))
        end
        rdchk(RIDX_DIR1, 32'h0000_00ff);
        axw(ra(RIDX_MODE), 32'h0000_0000);
    endtask

    task automatic t_errors();
        axr(12'h000);
        `CHK(resp, RESP_SLVERR)
        `CHK(rd_val, 32'h0000_0000)
        axw(12'h3a4, 32'h0000_0001);
        `CHK(resp, RESP_SLVERR)
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        t_reset();
        t_input();
        t_output();
        t_xbus();
        t_serial();
        t_errors();
        end_of_test();
    end
endmodule

`default_nettype wire
